// ===== quiet_cfg_pkg.sv
// Purpose: Constants for the inactivity detector register bank
// Assumes: 20 MHz core clock, byte-wide register port
// Notes:   Times are given in ns, cycle counts derived from them
package quiet_cfg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_LIMIT_X_HIGH = 8'h2A;
  localparam logic [7:0] OFS_LIMIT_X_LOW  = 8'h2B;
  localparam logic [7:0] OFS_LIMIT_Y_HIGH = 8'h2C;
  localparam logic [7:0] OFS_LIMIT_Y_LOW  = 8'h2D;
  localparam logic [7:0] OFS_LIMIT_Z_HIGH = 8'h2E;
  localparam logic [7:0] OFS_LIMIT_Z_LOW  = 8'h2F;
  localparam logic [7:0] OFS_TIME_HIGH    = 8'h30;
  localparam logic [7:0] OFS_TIME_LOW     = 8'h31;
  localparam logic [7:0] OFS_WARN_X_HIGH  = 8'h32;
  localparam logic [7:0] OFS_WARN_X_LOW   = 8'h33;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int         POS_AXIS_ENABLE = 0;
  localparam int         POS_REF_SELECT  = 1;
  localparam int         POS_LOW_BITS    = 5;
  localparam logic [7:0] MASK_X_LOW      = 8'hE3;
  localparam logic [7:0] MASK_YZ_LOW     = 8'hE1;
  localparam logic [7:0] MASK_WARN_LOW   = 8'hE0;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS     = 50;
  localparam int CODE_SLOW_NS      = 32500000;
  localparam int CODE_FAST_NS      = 16250000;
  localparam int CODE_SLOW_CYCLES  = CODE_SLOW_NS / CLK_PERIOD_NS;
  localparam int CODE_FAST_CYCLES  = CODE_FAST_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PH_IDLE, PH_TIMING, PH_QUIET} phase_e;

endpackage

// ===== quiet_detect_bank.sv
// Purpose: Inactivity detector configuration and timer
// Assumes: Samples and port strobes synchronous to clk
// Notes:   Read data appears one cycle after rd_en
`timescale 1ns/1ps

module quiet_detect_bank #(
  parameter int SLOW_CYCLES = quiet_cfg_pkg::CODE_SLOW_CYCLES,
  parameter int FAST_CYCLES = quiet_cfg_pkg::CODE_FAST_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  // Acceleration samples
  input  wire logic        sample_valid,
  input  wire logic [11:0] sample_x,
  input  wire logic [11:0] sample_y,
  input  wire logic [11:0] sample_z,
  input  wire logic        output_sample_rate_fast,
  // Detector outputs
  output logic             quiet_detect,
  output logic             motion_warning_detect
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]            lim_x_hi;
    logic [7:0]            lim_x_lo;
    logic [7:0]            lim_y_hi;
    logic [7:0]            lim_y_lo;
    logic [7:0]            lim_z_hi;
    logic [7:0]            lim_z_lo;
    logic [7:0]            dur_hi;
    logic [7:0]            dur_lo;
    logic [7:0]            warn_hi;
    logic [7:0]            warn_lo;
    logic [19:0]           tick;
    logic [15:0]           codes;
    quiet_cfg_pkg::phase_e phase;
    logic [11:0]           ref_x;
    logic [11:0]           ref_y;
    logic [11:0]           ref_z;
    logic                  quiet;
    logic                  warn;
    logic [7:0]            rd_data;
  } state_s;

  state_s st;
  state_s next_st;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [11:0] mag13(input logic [12:0] v);
    mag13 = v[12] ? 12'(-v) : v[11:0];
  endfunction

  function automatic logic below(input logic [11:0] s, input logic [11:0] r,
                                 input logic rsel, input logic [10:0] lim);
    logic [12:0] d;
    d = rsel ? ({s[11], s} - {r[11], r}) : {s[11], s};
    below = mag13(d) < {1'b0, lim};
  endfunction

  function automatic logic [10:0] limit_of(input logic [7:0] hi, input logic [7:0] lo);
    limit_of = {hi, lo[7:quiet_cfg_pkg::POS_LOW_BITS]};
  endfunction

  logic [10:0] quiet_limit_x;
  logic [10:0] quiet_limit_y;
  logic [10:0] quiet_limit_z;
  logic [10:0] motion_warning_limit_x;
  logic [15:0] quiet_duration_value;
  logic        quiet_referenced_select;
  logic        quiet_axis_x_enable;
  logic        quiet_axis_y_enable;
  logic        quiet_axis_z_enable;
  logic        any_enabled;
  logic        all_quiet;
  logic [19:0] period;

  assign quiet_limit_x           = limit_of(st.lim_x_hi, st.lim_x_lo);
  assign quiet_limit_y           = limit_of(st.lim_y_hi, st.lim_y_lo);
  assign quiet_limit_z           = limit_of(st.lim_z_hi, st.lim_z_lo);
  assign motion_warning_limit_x  = limit_of(st.warn_hi, st.warn_lo);
  assign quiet_duration_value    = {st.dur_hi, st.dur_lo};
  assign quiet_referenced_select = st.lim_x_lo[quiet_cfg_pkg::POS_REF_SELECT];
  assign quiet_axis_x_enable     = st.lim_x_lo[quiet_cfg_pkg::POS_AXIS_ENABLE];
  assign quiet_axis_y_enable     = st.lim_y_lo[quiet_cfg_pkg::POS_AXIS_ENABLE];
  assign quiet_axis_z_enable     = st.lim_z_lo[quiet_cfg_pkg::POS_AXIS_ENABLE];
  assign any_enabled = quiet_axis_x_enable | quiet_axis_y_enable | quiet_axis_z_enable;
  assign all_quiet =
    (!quiet_axis_x_enable | below(sample_x, st.ref_x, quiet_referenced_select, quiet_limit_x)) &
    (!quiet_axis_y_enable | below(sample_y, st.ref_y, quiet_referenced_select, quiet_limit_y)) &
    (!quiet_axis_z_enable | below(sample_z, st.ref_z, quiet_referenced_select, quiet_limit_z));
  assign period = output_sample_rate_fast ? 20'(FAST_CYCLES) : 20'(SLOW_CYCLES);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    // Register writes, reserved bits held at zero
    if (wr_en) begin
      unique case (addr)
        quiet_cfg_pkg::OFS_LIMIT_X_HIGH: next_st.lim_x_hi = wr_data;
        quiet_cfg_pkg::OFS_LIMIT_X_LOW:  next_st.lim_x_lo = wr_data & quiet_cfg_pkg::MASK_X_LOW;
        quiet_cfg_pkg::OFS_LIMIT_Y_HIGH: next_st.lim_y_hi = wr_data;
        quiet_cfg_pkg::OFS_LIMIT_Y_LOW:  next_st.lim_y_lo = wr_data & quiet_cfg_pkg::MASK_YZ_LOW;
        quiet_cfg_pkg::OFS_LIMIT_Z_HIGH: next_st.lim_z_hi = wr_data;
        quiet_cfg_pkg::OFS_LIMIT_Z_LOW:  next_st.lim_z_lo = wr_data & quiet_cfg_pkg::MASK_YZ_LOW;
        quiet_cfg_pkg::OFS_TIME_HIGH:    next_st.dur_hi   = wr_data;
        quiet_cfg_pkg::OFS_TIME_LOW:     next_st.dur_lo   = wr_data;
        quiet_cfg_pkg::OFS_WARN_X_HIGH:  next_st.warn_hi  = wr_data;
        quiet_cfg_pkg::OFS_WARN_X_LOW:   next_st.warn_lo  = wr_data & quiet_cfg_pkg::MASK_WARN_LOW;
        default: ;
      endcase
    end
    // Register reads, unmapped offsets give zero
    if (rd_en) begin
      unique case (addr)
        quiet_cfg_pkg::OFS_LIMIT_X_HIGH: next_st.rd_data = st.lim_x_hi;
        quiet_cfg_pkg::OFS_LIMIT_X_LOW:  next_st.rd_data = st.lim_x_lo;
        quiet_cfg_pkg::OFS_LIMIT_Y_HIGH: next_st.rd_data = st.lim_y_hi;
        quiet_cfg_pkg::OFS_LIMIT_Y_LOW:  next_st.rd_data = st.lim_y_lo;
        quiet_cfg_pkg::OFS_LIMIT_Z_HIGH: next_st.rd_data = st.lim_z_hi;
        quiet_cfg_pkg::OFS_LIMIT_Z_LOW:  next_st.rd_data = st.lim_z_lo;
        quiet_cfg_pkg::OFS_TIME_HIGH:    next_st.rd_data = st.dur_hi;
        quiet_cfg_pkg::OFS_TIME_LOW:     next_st.rd_data = st.dur_lo;
        quiet_cfg_pkg::OFS_WARN_X_HIGH:  next_st.rd_data = st.warn_hi;
        quiet_cfg_pkg::OFS_WARN_X_LOW:   next_st.rd_data = st.warn_lo;
        default:                         next_st.rd_data = quiet_cfg_pkg::REG_RESET;
      endcase
    end
    // Motion warning level, refreshed per sample
    if (sample_valid) begin
      next_st.warn = mag13({sample_x[11], sample_x}) > {1'b0, motion_warning_limit_x};
    end
    // Inactivity timer
    if (!any_enabled) begin
      next_st.phase = quiet_cfg_pkg::PH_IDLE;
      next_st.quiet = 1'b0;
      next_st.tick  = 20'h00000;
      next_st.codes = 16'h0000;
    end else if (sample_valid && (st.phase == quiet_cfg_pkg::PH_IDLE || !all_quiet)) begin
      // Restart and take a new reference baseline
      next_st.phase = quiet_cfg_pkg::PH_TIMING;
      next_st.quiet = 1'b0;
      next_st.tick  = 20'h00000;
      next_st.codes = 16'h0000;
      next_st.ref_x = sample_x;
      next_st.ref_y = sample_y;
      next_st.ref_z = sample_z;
    end else if (st.phase == quiet_cfg_pkg::PH_TIMING) begin
      if (st.codes >= quiet_duration_value) begin
        next_st.phase = quiet_cfg_pkg::PH_QUIET;
        next_st.quiet = 1'b1;
      end else if (st.tick >= period - 20'h00001) begin
        next_st.tick  = 20'h00000;
        next_st.codes = st.codes + 16'h0001;
      end else begin
        next_st.tick = st.tick + 20'h00001;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data               = st.rd_data;
  assign quiet_detect          = st.quiet;
  assign motion_warning_detect = st.warn;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence seq_write_y_high;
    wr_en && !rd_en && addr == quiet_cfg_pkg::OFS_LIMIT_Y_HIGH;
  endsequence

  sequence seq_read_y_high;
    rd_en && !wr_en && addr == quiet_cfg_pkg::OFS_LIMIT_Y_HIGH;
  endsequence

  chk_high_readback: assert property (
    seq_write_y_high ##1 !wr_en ##1 seq_read_y_high |=> rd_data == $past(wr_data, 3))
    else $error("high limit readback mismatch");

  chk_low_bits_field: assert property (
    wr_en && addr == quiet_cfg_pkg::OFS_LIMIT_Z_LOW |=> quiet_limit_z[2:0] == $past(wr_data[7:5]))
    else $error("low limit bits misplaced");

  chk_ref_select: assert property (
    wr_en && addr == quiet_cfg_pkg::OFS_LIMIT_X_LOW |=> quiet_referenced_select == $past(wr_data[1]))
    else $error("reference select not taken");

  chk_disabled_quiet: assert property (
    !any_enabled |=> !quiet_detect)
    else $error("inactivity with no axis enabled");

  chk_quiet_time: assert property (
    $rose(quiet_detect) |-> $past(st.codes) >= $past(quiet_duration_value))
    else $error("inactivity before programmed time");

  chk_time_bytes: assert property (
    wr_en && addr == quiet_cfg_pkg::OFS_TIME_LOW |=> quiet_duration_value[7:0] == $past(wr_data))
    else $error("time low byte misplaced");

  chk_code_period: assert property (
    st.phase == quiet_cfg_pkg::PH_TIMING && $past(st.phase) == quiet_cfg_pkg::PH_TIMING
      && st.codes == $past(st.codes) + 16'h0001 |-> $past(st.tick) == $past(period) - 20'h00001)
    else $error("time code step off period");

  chk_warn_compare: assert property (
    sample_valid |=> motion_warning_detect ==
      ($past(mag13({sample_x[11], sample_x})) > {1'b0, $past(motion_warning_limit_x)}))
    else $error("motion warning compare wrong");

  chk_warn_high: assert property (
    wr_en && addr == quiet_cfg_pkg::OFS_WARN_X_HIGH |=> motion_warning_limit_x[10:3] == $past(wr_data))
    else $error("warning high byte misplaced");

  chk_reserved_zero: assert property (
    rd_en && addr == quiet_cfg_pkg::OFS_LIMIT_X_LOW |=> rd_data[4:2] == 3'h0)
    else $error("reserved bits read nonzero");

  chk_quiet_restart: assert property (
    sample_valid && any_enabled && !all_quiet |=> !quiet_detect && st.codes == 16'h0000)
    else $error("timer not restarted on motion");

  chk_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
    !arst_n |-> rd_data == 8'h00 && !quiet_detect && quiet_duration_value == 16'h0000)
    else $error("reset values not zero");

endmodule

// ===== quiet_detect_bank_test.sv
// Purpose: Self-checking bench for the inactivity detector register bank
// Assumes: Code periods shortened to 20 and 10 clocks
// Notes:   Read results are compared by a monitor against a queue of notes
`timescale 1ns/1ps

module quiet_detect_bank_test;

  // ****************************************
  // Signals
  // ****************************************
  localparam int SLOW = 20;
  localparam int FAST = 10;
  logic        clk;
  logic        arst_n;
  logic        wr_en;
  logic        rd_en;
  logic        rd_seen = 1'b0;
  logic        sample_valid;
  logic        rate_fast;
  logic        quiet_detect;
  logic        motion_warning_detect;
  logic [7:0]  addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [7:0]  rnd;
  logic [11:0] sample_x;
  logic [11:0] sample_y;
  logic [11:0] sample_z;
  logic [7:0]  exp_q[$];
  int          fails;
  int          checked;
  int unsigned seed_val;
  logic [11:0] warn_in [4] = '{12'h064, 12'h065, 12'hF9B, 12'hF9C};
  logic        warn_exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  quiet_detect_bank #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) quiet_detect_bank_inst (
    .clk                     (clk),
    .arst_n                  (arst_n),
    .wr_en                   (wr_en),
    .rd_en                   (rd_en),
    .addr                    (addr),
    .wr_data                 (wr_data),
    .rd_data                 (rd_data),
    .sample_valid            (sample_valid),
    .sample_x                (sample_x),
    .sample_y                (sample_y),
    .sample_z                (sample_z),
    .output_sample_rate_fast (rate_fast),
    .quiet_detect            (quiet_detect),
    .motion_warning_detect   (motion_warning_detect)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic samp(input logic [11:0] x);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_x     <= x;
    sample_y     <= 12'h7FF;
    sample_z     <= 12'h800;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask

  // Quiet sample, then flag low before and high after two code periods
  task automatic quiet_run(input int per);
    samp(12'h00A);
    repeat (2 * per - 5) @(posedge clk);
    check({7'h00, quiet_detect}, 8'h00);
    repeat (10) @(posedge clk);
    check({7'h00, quiet_detect}, 8'h01);
  endtask

  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      quiet_cfg_pkg::OFS_LIMIT_X_LOW: return quiet_cfg_pkg::MASK_X_LOW;
      quiet_cfg_pkg::OFS_LIMIT_Y_LOW,
      quiet_cfg_pkg::OFS_LIMIT_Z_LOW: return quiet_cfg_pkg::MASK_YZ_LOW;
      quiet_cfg_pkg::OFS_WARN_X_LOW:  return quiet_cfg_pkg::MASK_WARN_LOW;
      default:                        return 8'hFF;
    endcase
  endfunction

  // ****************************************
  // Clock, monitor and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd_seen) begin
      check(rd_data, exp_q.pop_front());
    end
    rd_seen <= rd_en;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_sim();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {wr_en, rd_en, sample_valid, rate_fast} = '0;
    arst_n = 1'b1;
    {addr, wr_data, sample_x, sample_y, sample_z} = '0;
    fails    = 0;
    checked  = 0;
    seed_val = $urandom(14217);
    // Reset taken on an edge so the flops see a clean fall
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 8'h2A; a <= 8'h33; a++) rd(8'(a), quiet_cfg_pkg::REG_RESET);
    rd(8'h40, 8'h00);
    $display("reset values done");
    for (int a = 8'h2A; a <= 8'h33; a++) begin
      rnd = 8'($urandom);
      wr(8'(a), rnd);
      rd(8'(a), rnd & mask(8'(a)));
    end
    wr(8'h40, 8'hA5);
    rd(8'h40, 8'h00);
    $display("register access done");
    wr(quiet_cfg_pkg::OFS_WARN_X_HIGH, 8'h0C);
    wr(quiet_cfg_pkg::OFS_WARN_X_LOW, 8'h80);
    for (int i = 0; i < 4; i++) begin
      samp(warn_in[i]);
      @(posedge clk);
      check({7'h00, motion_warning_detect}, {7'h00, warn_exp[i]});
    end
    $display("motion warning done");
    wr(quiet_cfg_pkg::OFS_LIMIT_X_HIGH, 8'h06);
    wr(quiet_cfg_pkg::OFS_LIMIT_Y_LOW, 8'h00);
    wr(quiet_cfg_pkg::OFS_LIMIT_Z_LOW, 8'h00);
    wr(quiet_cfg_pkg::OFS_TIME_HIGH, 8'h00);
    wr(quiet_cfg_pkg::OFS_TIME_LOW, 8'h02);
    wr(quiet_cfg_pkg::OFS_LIMIT_X_LOW, 8'h40);
    wr(quiet_cfg_pkg::OFS_LIMIT_X_LOW, 8'h41);
    quiet_run(SLOW);
    samp(12'h032);
    repeat (2) @(posedge clk);
    check({7'h00, quiet_detect}, 8'h00);
    rate_fast <= 1'b1;
    wr(quiet_cfg_pkg::OFS_LIMIT_X_LOW, 8'h40);
    wr(quiet_cfg_pkg::OFS_LIMIT_X_LOW, 8'h41);
    quiet_run(FAST);
    wr(quiet_cfg_pkg::OFS_LIMIT_X_LOW, 8'h40);
    repeat (2) @(posedge clk);
    check({7'h00, quiet_detect}, 8'h00);
    // Referenced mode: second sample near the baseline must not restart
    wr(quiet_cfg_pkg::OFS_LIMIT_X_LOW, 8'h43);
    samp(12'h400);
    repeat (FAST) @(posedge clk);
    samp(12'h40A);
    repeat (FAST + 5) @(posedge clk);
    check({7'h00, quiet_detect}, 8'h01);
    $display("inactivity timer done");
    repeat (3) @(posedge clk);
    end_sim();
  end

endmodule
